// file: hdl/dctm_top.sv
// Two counter/timers with 13-bit, 16-bit and 8-bit reload modes, APB register access.
// Assumes event and gate pins are already synchronous to pclk.
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module dctm_top
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Event and gate pins
   input wire logic first_event_input_pin,
   input wire logic second_event_input_pin,
   input wire logic ext_irq_input_a,
   input wire logic ext_irq_input_b,
   // Interrupt
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [1:0] timer_control_register;
   logic [7:0] timer_mode_register;
   logic [3:0] clock_scale_register;
   logic [1:0] ext_irq_config_register;
   logic [1:0] ovf_flag;
   logic [1:0] interrupt_enable_register;
   logic [7:0] cnt_lo [2];
   logic [7:0] cnt_hi [2];
   logic [5:0] presc_cnt;
   logic [1:0] evt_prev;
   logic [31:0] next_prdata;

   ////////////////////////////////////////////////////////////////////////////////
   // APB decode; zero wait states, unmapped addresses answer with pslverr

   wire logic wr_acc = psel & penable & pwrite;
   wire logic rd_setup = psel & ~penable & ~pwrite;
   wire logic hit_ctrl = (paddr == dctm_pkg::OFF_CTRL);
   wire logic hit_mode = (paddr == dctm_pkg::OFF_MODE);
   wire logic hit_scale = (paddr == dctm_pkg::OFF_SCALE);
   wire logic hit_ext = (paddr == dctm_pkg::OFF_EXTCFG);
   wire logic hit_stat = (paddr == dctm_pkg::OFF_STATUS);
   wire logic hit_irqen = (paddr == dctm_pkg::OFF_IRQEN);
   wire logic [1:0] hit_lo = {paddr == dctm_pkg::OFF_T1_LO, paddr == dctm_pkg::OFF_T0_LO};
   wire logic [1:0] hit_hi = {paddr == dctm_pkg::OFF_T1_HI, paddr == dctm_pkg::OFF_T0_HI};
   wire logic addr_ok = hit_ctrl | hit_mode | hit_scale | hit_ext | hit_stat | hit_irqen
                        | (|hit_lo) | (|hit_hi);

   assign pready = 1'b1;
   assign pslverr = psel & penable & ~addr_ok;

   // Read mux, sampled in the setup phase so prdata comes from a flip-flop
   always_comb
   begin
      next_prdata = 32'h0000_0000;
      if (hit_ctrl)
         next_prdata[1:0] = timer_control_register;
      if (hit_mode)
         next_prdata[7:0] = timer_mode_register;
      if (hit_scale)
         next_prdata[3:0] = clock_scale_register;
      if (hit_ext)
         next_prdata[1:0] = ext_irq_config_register;
      if (hit_stat)
         next_prdata[1:0] = ovf_flag;
      if (hit_irqen)
         next_prdata[1:0] = interrupt_enable_register;
      for (int i = 0; i < 2; i++)
      begin
         if (hit_lo[i])
            next_prdata[7:0] = cnt_lo[i];
         if (hit_hi[i])
            next_prdata[7:0] = cnt_hi[i];
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_setup)
         prdata <= next_prdata;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Prescaler shared by both timers

   wire logic [1:0] presc_sel =
      clock_scale_register[dctm_pkg::SCALE_LSB +: dctm_pkg::SCALE_W];
   wire logic [5:0] presc_div = (presc_sel == 2'h0) ? dctm_pkg::PRESC_DIV0 :
                                (presc_sel == 2'h1) ? dctm_pkg::PRESC_DIV1 :
                                (presc_sel == 2'h2) ? dctm_pkg::PRESC_DIV2 :
                                dctm_pkg::PRESC_DIV3;
   // Compare with >= so a smaller ratio written mid-count cannot strand the counter
   wire logic presc_tick = (presc_cnt >= presc_div - 6'h01);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         presc_cnt <= 6'h00;
      else
         presc_cnt <= presc_tick ? 6'h00 : presc_cnt + 6'h01;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Per-timer source selection, gating and next count

   wire logic [1:0] evt_pin = {second_event_input_pin, first_event_input_pin};
   wire logic [1:0] gate_pin = {ext_irq_input_b, ext_irq_input_a};
   // One registered stage: a level held two cycles is always seen by the edge detector
   wire logic [1:0] evt_fall = evt_prev & ~evt_pin;

   dctm_pkg::dctm_tcfg_t cfg [2];
   dctm_pkg::dctm_step_t step [2];
   logic [1:0] int_tick;
   logic [1:0] src_tick;
   logic [1:0] gate_ok;
   logic [1:0] adv;
   logic [1:0] ovf_set;
   logic [1:0] cnt_wr;

   for (genvar i = 0; i < 2; i++)
   begin : g_tmr
      assign cfg[i] = dctm_pkg::dctm_tcfg_t'(timer_mode_register[i*dctm_pkg::MODE_NIB_W +:
                                                                 dctm_pkg::MODE_NIB_W]);
      assign int_tick[i] = clock_scale_register[dctm_pkg::CLKSEL_LSB + i]
                           | presc_tick;
      assign src_tick[i] = cfg[i].ct ? evt_fall[i] : int_tick[i];
      assign gate_ok[i] = ~cfg[i].gate
                          | (gate_pin[i] == ext_irq_config_register[dctm_pkg::POL_LSB + i]);
      // The split mode is not provided here, so a timer in it simply holds
      assign adv[i] = timer_control_register[dctm_pkg::RUN_LSB + i] & gate_ok[i] & src_tick[i]
                      & (cfg[i].mode != dctm_pkg::DCTM_MSPLIT);
      assign step[i] = dctm_pkg::dctm_count_step(cfg[i].mode, cnt_hi[i], cnt_lo[i]);
      assign ovf_set[i] = adv[i] & step[i].ovf;
      assign cnt_wr[i] = wr_acc & (hit_lo[i] | hit_hi[i]);
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Count registers; a software byte write beats a count step on that byte

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         evt_prev <= 2'h0;
         for (int i = 0; i < 2; i++)
         begin
            cnt_lo[i] <= dctm_pkg::RST_COUNT;
            cnt_hi[i] <= dctm_pkg::RST_COUNT;
         end
      end
      else
      begin
         evt_prev <= evt_pin;
         for (int i = 0; i < 2; i++)
         begin
            if (wr_acc & hit_lo[i])
               cnt_lo[i] <= pwdata[7:0];
            else if (adv[i])
               cnt_lo[i] <= step[i].cnt[7:0];
            if (wr_acc & hit_hi[i])
               cnt_hi[i] <= pwdata[7:0];
            else if (adv[i])
               cnt_hi[i] <= step[i].cnt[15:8];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Configuration registers; run does not touch the count

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         timer_control_register <= dctm_pkg::RST_CTRL;
         timer_mode_register <= dctm_pkg::RST_MODE;
         clock_scale_register <= dctm_pkg::RST_SCALE;
         ext_irq_config_register <= dctm_pkg::RST_EXTCFG;
         interrupt_enable_register <= dctm_pkg::RST_IRQEN;
      end
      else if (wr_acc)
      begin
         if (hit_ctrl)
            timer_control_register <= pwdata[1:0];
         if (hit_mode)
            timer_mode_register <= pwdata[7:0];
         if (hit_scale)
            clock_scale_register <= pwdata[3:0];
         if (hit_ext)
            ext_irq_config_register <= pwdata[1:0];
         if (hit_irqen)
            interrupt_enable_register <= pwdata[1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Overflow flags: sticky, write one to clear, a new overflow wins over the clear

   wire logic [1:0] flag_clr = (wr_acc & hit_stat) ? pwdata[1:0] : 2'h0;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ovf_flag <= dctm_pkg::RST_STATUS;
      else
         ovf_flag <= (ovf_flag & ~flag_clr) | ovf_set;
   end

   // Level interrupt while any enabled flag stands
   assign irq = |(ovf_flag & interrupt_enable_register);

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   wire logic t0_quiet = ~cnt_wr[0];
   wire logic t0_on = timer_control_register[0] & gate_ok[0];
   wire logic t1_quiet = ~cnt_wr[1];
   wire logic [15:0] cnt0 = {cnt_hi[0], cnt_lo[0]};
   wire logic [15:0] cnt1 = {cnt_hi[1], cnt_lo[1]};
   wire logic [12:0] cnt1_13 = {cnt_hi[1], cnt_lo[1][4:0]};

   sequence s_t0_reload_edge;
      adv[0] && cfg[0].mode == dctm_pkg::DCTM_M8R && cnt_lo[0] == 8'hff && t0_quiet;
   endsequence

   sequence s_t0_reloaded;
      cnt_lo[0] == $past(cnt_hi[0]) && cnt_hi[0] == $past(cnt_hi[0]) && ovf_flag[0];
   endsequence

   AST_T0_RELOAD: assert property (s_t0_reload_edge |=> s_t0_reloaded)
      else $error("Timer 0 8-bit reload wrong");

   AST_T0_WRAP16: assert property (adv[0] && cfg[0].mode == dctm_pkg::DCTM_M16
                                    && {cnt_hi[0], cnt_lo[0]} == 16'hffff && t0_quiet
                                    |=> {cnt_hi[0], cnt_lo[0]} == 16'h0000 && ovf_flag[0])
      else $error("Timer 0 16-bit wrap did not set flag");

   AST_T1_WRAP13: assert property (adv[1] && cfg[1].mode == dctm_pkg::DCTM_M13
                                    && cnt_hi[1] == 8'hff && cnt_lo[1][4:0] == 5'h1f && t1_quiet
                                    |=> cnt_hi[1] == 8'h00 && cnt_lo[1][4:0] == 5'h00
                                        && ovf_flag[1])
      else $error("Timer 1 13-bit wrap wrong");

   AST_T0_STOPPED: assert property (!timer_control_register[0] && t0_quiet
                                     |=> $stable({cnt_hi[0], cnt_lo[0]}))
      else $error("Timer 0 moved while stopped");

   AST_T0_GATED: assert property (cfg[0].gate && ext_irq_input_a != ext_irq_config_register[0]
                                   && t0_quiet |=> $stable({cnt_hi[0], cnt_lo[0]}))
      else $error("Timer 0 moved while gated off");

   AST_T0_SYSCLK: assert property (t0_on && !cfg[0].ct && clock_scale_register[2]
                                    && cfg[0].mode == dctm_pkg::DCTM_M16 && t0_quiet
                                    |=> {cnt_hi[0], cnt_lo[0]} == $past({cnt_hi[0], cnt_lo[0]})
                                                                  + 16'h0001)
      else $error("Timer 0 missed a system clock step");

   AST_T0_EVENT: assert property (t0_on && cfg[0].ct && cfg[0].mode == dctm_pkg::DCTM_M16
                                   && t0_quiet && !(evt_prev[0] && !first_event_input_pin)
                                   |=> $stable({cnt_hi[0], cnt_lo[0]}))
      else $error("Timer 0 counted without a falling edge");

   AST_T1_EVENT: assert property (timer_control_register[1] && gate_ok[1] && cfg[1].ct
                                   && cfg[1].mode == dctm_pkg::DCTM_M16 && ~cnt_wr[1]
                                   && evt_prev[1] && !second_event_input_pin
                                   |=> cnt_lo[1] == $past(cnt_lo[1]) + 8'h01
                                       || cnt_lo[1] == 8'h00)
      else $error("Timer 1 missed a falling edge");

   AST_IRQ_ENABLE: assert property (ovf_set[0] && interrupt_enable_register[0]
                                     && !(wr_acc && hit_irqen) |=> irq)
      else $error("Enabled overflow did not raise irq");

   AST_IRQ_MASKED: assert property (interrupt_enable_register == 2'h0 |-> !irq)
      else $error("Masked overflow raised irq");

   ////////////////////////////////////////////////////////////////////////////////
   // Second timer, prescaler, timer 0 reload, split and gate, byte access and flags

   // Timer 1 on the system clock in 13-bit mode
   sequence s_t1_fast13;
      timer_control_register[1] && gate_ok[1] && !cfg[1].ct && clock_scale_register[3]
         && cfg[1].mode == dctm_pkg::DCTM_M13 && t1_quiet;
   endsequence

   sequence s_t1_next13;
      cnt1_13 == $past(cnt1_13) + 13'h0001 && cnt_lo[1][7:5] == $past(cnt_lo[1][7:5]);
   endsequence

   AST_T1_SYSCLK13: assert property (s_t1_fast13 |=> s_t1_next13)
      else $error("Timer 1 13-bit step wrong");

   AST_T1_STOPPED: assert property (!timer_control_register[1] && t1_quiet
      |=> $stable(cnt1))
      else $error("Timer 1 moved while stopped");

   AST_T1_NO_EVENT: assert property (timer_control_register[1] && gate_ok[1]
      && cfg[1].ct && cfg[1].mode == dctm_pkg::DCTM_M16 && t1_quiet && !evt_fall[1]
      |=> $stable(cnt1))
      else $error("Timer 1 counted with no edge");

   AST_T0_PRESC: assert property (t0_on && !cfg[0].ct
      && !clock_scale_register[2] && cfg[0].mode == dctm_pkg::DCTM_M16 && t0_quiet
      |=> cnt0 == $past(cnt0) + {15'h0000, $past(presc_tick)})
      else $error("Timer 0 prescaled step wrong");

   sequence s_t0_m8r_adv;
      adv[0] && cfg[0].mode == dctm_pkg::DCTM_M8R && t0_quiet;
   endsequence

   AST_T0_M8R_HI: assert property (s_t0_m8r_adv |=> cnt_hi[0] == $past(cnt_hi[0]))
      else $error("Timer 0 reload value moved");

   AST_T0_M8R_STEP: assert property (s_t0_m8r_adv ##0 (cnt_lo[0] != 8'hff)
      |=> cnt_lo[0] == $past(cnt_lo[0]) + 8'h01)
      else $error("Timer 0 8-bit step wrong");

   AST_T0_SPLIT_HOLD: assert property (cfg[0].mode == dctm_pkg::DCTM_MSPLIT
      && t0_quiet |=> $stable(cnt0))
      else $error("Timer 0 moved in split mode");

   sequence s_t0_gate_open;
      timer_control_register[0] && cfg[0].gate
         && ext_irq_input_a == ext_irq_config_register[0];
   endsequence

   AST_T0_GATE_OPEN: assert property (s_t0_gate_open ##0
      (cfg[0].ct && evt_fall[0] && cfg[0].mode == dctm_pkg::DCTM_M16 && t0_quiet)
      |=> cnt0 == $past(cnt0) + 16'h0001)
      else $error("Timer 0 missed a gated event");

   AST_RD_LO: assert property (rd_setup && hit_lo[0]
      |=> prdata[7:0] == $past(cnt_lo[0]))
      else $error("Timer 0 low read wrong");

   AST_WR_LO: assert property (wr_acc && hit_lo[0]
      |=> cnt_lo[0] == $past(pwdata[7:0]))
      else $error("Timer 0 low write lost");

   AST_WR_HI1: assert property (wr_acc && hit_hi[1]
      |=> cnt_hi[1] == $past(pwdata[7:0]))
      else $error("Timer 1 high write lost");

   // Sticky until a one is written; a new overflow beats the clear
   AST_FLAG_HOLD: assert property (ovf_flag[0] && !flag_clr[0] |=> ovf_flag[0])
      else $error("Timer 0 flag dropped");

   AST_FLAG_CLR: assert property (flag_clr[0] && !ovf_set[0] |=> !ovf_flag[0])
      else $error("Timer 0 flag stuck");

   AST_FLAG_SET: assert property (ovf_set[0] |=> ovf_flag[0])
      else $error("Timer 0 flag not set");

endmodule

`default_nettype wire

// file: pkg/dctm_pkg.sv
// Constants, types and helpers for the dual counter/timer block.
// Assumes a single system clock and software access through an APB slave.
//
// Summary of operation
// - Each timer's timebase is one of five sources, picked by its clock select bit and the shared prescale field.
// - As a counter, a timer advances by one on each high-to-low transition of its event pin.
// - Events up to a quarter of the clock rate are counted; the source holds each level two cycles or more.
// - Each timer has a 16-bit count that software reads and writes as a low byte and a high byte.
// - Each timer runs in one of four modes set by its own two-bit field, independently of the other; here split mode only holds the count.
// - In 13-bit mode the high byte holds the eight upper bits and low bits 4..0 the five lower bits.
// - In 13-bit mode a wrap from 0x1fff to 0x0000 sets the overflow flag and may request an interrupt.
// - The counter/timer select bit picks event pin edges when set, the internal clock when clear.
// - The clock select bit picks the system clock when set, the prescaled clock when clear.
// - A timer counts only while run is 1 and either gate is 0 or its external input is active.
// - Setting run does not clear the count; software loads the start value first.
// - The second timer behaves like the first with its own bytes, controls, input and polarity.
// - 16-bit mode behaves like 13-bit mode but uses all 16 bits of the byte pair.
// - In 8-bit reload mode the low byte counts and on wrap sets the flag and reloads from the high byte.
// - An overflow flag raises the interrupt only when that timer's enable bit is set.
`default_nettype none

package dctm_pkg;

   // Register byte offsets on APB
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_MODE = 8'h04;
   localparam logic [7:0] OFF_SCALE = 8'h08;
   localparam logic [7:0] OFF_EXTCFG = 8'h0c;
   localparam logic [7:0] OFF_STATUS = 8'h10;
   localparam logic [7:0] OFF_IRQEN = 8'h14;
   localparam logic [7:0] OFF_T0_LO = 8'h18;
   localparam logic [7:0] OFF_T0_HI = 8'h1c;
   localparam logic [7:0] OFF_T1_LO = 8'h20;
   localparam logic [7:0] OFF_T1_HI = 8'h24;

   // Field positions (timer i uses bit LSB+i, or nibble i of the mode register)
   localparam int RUN_LSB = 0;
   localparam int MODE_NIB_W = 4;
   localparam int SCALE_LSB = 0;
   localparam int SCALE_W = 2;
   localparam int CLKSEL_LSB = 2;
   localparam int POL_LSB = 0;

   // Reset values
   localparam logic [1:0] RST_CTRL = 2'h0;
   localparam logic [7:0] RST_MODE = 8'h00;
   localparam logic [3:0] RST_SCALE = 4'h0;
   localparam logic [1:0] RST_EXTCFG = 2'h0;
   localparam logic [1:0] RST_STATUS = 2'h0;
   localparam logic [1:0] RST_IRQEN = 2'h0;
   localparam logic [7:0] RST_COUNT = 8'h00;

   // Prescaler divide ratios for each prescale field value
   localparam logic [5:0] PRESC_DIV0 = 6'h0c;
   localparam logic [5:0] PRESC_DIV1 = 6'h04;
   localparam logic [5:0] PRESC_DIV2 = 6'h30;
   localparam logic [5:0] PRESC_DIV3 = 6'h08;

   // Operating modes
   typedef enum logic [1:0] {
      DCTM_M13 = 2'h0,
      DCTM_M16 = 2'h1,
      DCTM_M8R = 2'h2,
      DCTM_MSPLIT = 2'h3
   } dctm_mode_t;

   // One timer's nibble of the mode register
   typedef struct packed {
      logic gate;
      logic ct;
      dctm_mode_t mode;
   } dctm_tcfg_t;

   // Result of one counting step
   typedef struct packed {
      logic [15:0] cnt;
      logic ovf;
   } dctm_step_t;

   // Next count value and overflow for a single advance
   function automatic dctm_step_t dctm_count_step(dctm_mode_t mode, logic [7:0] hi,
                                                  logic [7:0] lo);
      dctm_step_t s;
      logic [12:0] v13;
      s = '{cnt: {hi, lo}, ovf: 1'b0};
      v13 = {hi, lo[4:0]} + 13'h0001;
      case (mode)
         DCTM_M13:
         begin
            // Upper low-byte bits are left as they were
            s.cnt = {v13[12:5], lo[7:5], v13[4:0]};
            s.ovf = ({hi, lo[4:0]} == 13'h1fff);
         end
         DCTM_M16:
         begin
            s.cnt = {hi, lo} + 16'h0001;
            s.ovf = ({hi, lo} == 16'hffff);
         end
         DCTM_M8R:
         begin
            s.ovf = (lo == 8'hff);
            s.cnt = s.ovf ? {hi, hi} : {hi, lo + 8'h01};
         end
         default:
         begin
            s.cnt = {hi, lo};
            s.ovf = 1'b0;
         end
      endcase
      return s;
   endfunction

endpackage

`default_nettype wire

// file: verif/dctm_pin_model.sv
// Far-side model of the timer pins: event pulse sources and gate levels.
// Assumes bench requests arrive one clock wide, synchronous to pclk.
`timescale 1ns/100ps
`default_nettype none

module dctm_pin_model
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Requests from the bench
   input wire logic [1:0] pulse_req,
   input wire logic [1:0] gate_lvl,
   // Pins towards the block
   output logic [1:0] event_pin,
   output logic [1:0] gate_pin,
   output logic [1:0] busy
);
   logic [1:0] phase [2];

   //////////////////////////////////////////////////////////////////////
   // A pulse is in progress while its phase is non-zero
   assign busy = {phase[1] != 2'h0, phase[0] != 2'h0};

   // Each pulse holds low two cycles, then high two, so every level is sampled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         phase[0] <= 2'h0;
         phase[1] <= 2'h0;
         event_pin <= 2'h3;
         gate_pin <= 2'h0;
      end
      else
      begin
         gate_pin <= gate_lvl;
         for (int i = 0; i < 2; i++)
         begin
            if (phase[i] != 2'h0)
            begin
               phase[i] <= phase[i] + 2'h1;
               event_pin[i] <= (phase[i] >= 2'h2);
            end
            else if (pulse_req[i])
            begin
               phase[i] <= 2'h1;
               event_pin[i] <= 1'b0;
            end
         end
      end
   end
endmodule

`default_nettype wire

// file: verif/dual_counter_timer_modes_tb.sv
// Self-checking bench for the dual counter/timer block over APB.
// Assumes the pin model is compiled first; one clock, no wait states assumed.
`timescale 1ns/100ps
`default_nettype none

module dual_counter_timer_modes_tb;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [1:0] pulse_req, gate_lvl, event_pin, gate_pin, busy;
   int mismatches, comparisons, cycles;

   dctm_top DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .first_event_input_pin(event_pin[0]),
      .second_event_input_pin(event_pin[1]), .ext_irq_input_a(gate_pin[0]),
      .ext_irq_input_b(gate_pin[1]), .irq(irq));
   dctm_pin_model pins (.pclk(pclk), .presetn(presetn), .pulse_req(pulse_req),
      .gate_lvl(gate_lvl), .event_pin(event_pin), .gate_pin(gate_pin), .busy(busy));

   //////////////////////////////////////////////////////////////////////
   // Clock and hang guard; the tests need well under 3000 cycles
   always #50 pclk = ~pclk;
   always @(posedge pclk)
   begin
      cycles++;
      if (cycles == 6000)
      begin
         mismatches++;
         end_sim();
      end
   end

   //////////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                      output logic [31:0] rdat, output logic err);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= data;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rdat = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] addr, input logic [31:0] data);
      logic [31:0] d;
      logic e;
      apb(1'b1, addr, data, d, e);
   endtask

   task automatic rd_chk(input logic [7:0] addr, input logic [31:0] mask, input logic [31:0] exp);
      logic [31:0] d;
      logic e;
      apb(1'b0, addr, 32'h0, d, e);
      check(d & mask, exp);
   endtask

   // Irq is combinational from registers, so look once the edge has settled
   task automatic irq_chk(input logic exp);
      @(negedge pclk);
      check({31'h0, irq}, {31'h0, exp});
   endtask

   task automatic pulse(input int i);
      @(posedge pclk);
      pulse_req[i] <= 1'b1;
      @(posedge pclk);
      pulse_req[i] <= 1'b0;
      @(posedge pclk);
      while (busy[i] !== 1'b0)
         @(posedge pclk);
      repeat (2) @(posedge pclk);
   endtask

   //////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      logic [31:0] d;
      logic e;
      for (int a = 0; a <= 36; a += 4)
         rd_chk(8'(a), 32'hffffffff, 32'h0);
      apb(1'b0, 8'h40, 32'h0, d, e);
      check({31'h0, e}, 32'h1);
      check(d, 32'h0);
      check({31'h0, pready}, 32'h1);
      $display("test reset done");
   endtask

   // Run for exactly three edges: start 0xfffe wraps to 0x0001
   task automatic t_m16;
      wr(dctm_pkg::OFF_SCALE, 32'h4);
      wr(dctm_pkg::OFF_MODE, 32'h1);
      wr(dctm_pkg::OFF_T0_LO, 32'hfe);
      wr(dctm_pkg::OFF_T0_HI, 32'hff);
      wr(dctm_pkg::OFF_IRQEN, 32'h1);
      wr(dctm_pkg::OFF_CTRL, 32'h1);
      wr(dctm_pkg::OFF_CTRL, 32'h0);
      rd_chk(dctm_pkg::OFF_T0_LO, 32'hff, 32'h01);
      rd_chk(dctm_pkg::OFF_T0_HI, 32'hff, 32'h00);
      rd_chk(dctm_pkg::OFF_STATUS, 32'h3, 32'h1);
      irq_chk(1'b1);
      wr(dctm_pkg::OFF_IRQEN, 32'h0);
      irq_chk(1'b0);
      wr(dctm_pkg::OFF_IRQEN, 32'h1);
      irq_chk(1'b1);
      wr(dctm_pkg::OFF_STATUS, 32'h1);
      irq_chk(1'b0);
      $display("test 16-bit done");
   endtask

   // Second timer in 13-bit mode while the first keeps its count
   task automatic t_m13;
      wr(dctm_pkg::OFF_SCALE, 32'h8);
      wr(dctm_pkg::OFF_T1_LO, 32'hfe);
      wr(dctm_pkg::OFF_T1_HI, 32'hff);
      wr(dctm_pkg::OFF_CTRL, 32'h2);
      wr(dctm_pkg::OFF_CTRL, 32'h0);
      rd_chk(dctm_pkg::OFF_T1_LO, 32'h1f, 32'h01);
      rd_chk(dctm_pkg::OFF_T1_HI, 32'hff, 32'h00);
      rd_chk(dctm_pkg::OFF_STATUS, 32'h3, 32'h2);
      rd_chk(dctm_pkg::OFF_T0_LO, 32'hff, 32'h01);
      wr(dctm_pkg::OFF_STATUS, 32'h2);
      $display("test 13-bit done");
   endtask

   task automatic t_m8r;
      wr(dctm_pkg::OFF_SCALE, 32'h4);
      wr(dctm_pkg::OFF_MODE, 32'h2);
      wr(dctm_pkg::OFF_T0_HI, 32'h80);
      wr(dctm_pkg::OFF_T0_LO, 32'hfe);
      wr(dctm_pkg::OFF_CTRL, 32'h1);
      wr(dctm_pkg::OFF_CTRL, 32'h0);
      rd_chk(dctm_pkg::OFF_T0_LO, 32'hff, 32'h81);
      rd_chk(dctm_pkg::OFF_T0_HI, 32'hff, 32'h80);
      rd_chk(dctm_pkg::OFF_STATUS, 32'h3, 32'h1);
      wr(dctm_pkg::OFF_STATUS, 32'h1);
      wr(dctm_pkg::OFF_MODE, 32'h3);
      wr(dctm_pkg::OFF_CTRL, 32'h1);
      wr(dctm_pkg::OFF_CTRL, 32'h0);
      rd_chk(dctm_pkg::OFF_T0_LO, 32'hff, 32'h81);
      $display("test reload done");
   endtask

   // 96 run edges is a whole number of ticks for every ratio
   task automatic t_prescale;
      logic [5:0] div [4];
      div = '{dctm_pkg::PRESC_DIV0, dctm_pkg::PRESC_DIV1, dctm_pkg::PRESC_DIV2,
              dctm_pkg::PRESC_DIV3};
      wr(dctm_pkg::OFF_MODE, 32'h1);
      for (int s = 0; s < 4; s++)
      begin
         wr(dctm_pkg::OFF_SCALE, 32'(s));
         wr(dctm_pkg::OFF_T0_LO, 32'h0);
         wr(dctm_pkg::OFF_T0_HI, 32'h0);
         wr(dctm_pkg::OFF_CTRL, 32'h1);
         repeat (93) @(posedge pclk);
         wr(dctm_pkg::OFF_CTRL, 32'h0);
         rd_chk(dctm_pkg::OFF_T0_LO, 32'hff, 32'h60 / {26'h0, div[s]});
      end
      $display("test prescale done");
   endtask

   task automatic t_events;
      wr(dctm_pkg::OFF_SCALE, 32'h0);
      wr(dctm_pkg::OFF_MODE, 32'h55);
      wr(dctm_pkg::OFF_T0_LO, 32'h0);
      wr(dctm_pkg::OFF_T1_LO, 32'h0);
      wr(dctm_pkg::OFF_EXTCFG, 32'h1);
      wr(dctm_pkg::OFF_CTRL, 32'h3);
      repeat (3) pulse(0);
      rd_chk(dctm_pkg::OFF_T0_LO, 32'hff, 32'h03);
      repeat (2) pulse(1);
      rd_chk(dctm_pkg::OFF_T1_LO, 32'hff, 32'h02);
      wr(dctm_pkg::OFF_MODE, 32'h5d);
      repeat (2) pulse(0);
      rd_chk(dctm_pkg::OFF_T0_LO, 32'hff, 32'h03);
      gate_lvl[0] <= 1'b1;
      repeat (2) pulse(0);
      rd_chk(dctm_pkg::OFF_T0_LO, 32'hff, 32'h05);
      wr(dctm_pkg::OFF_EXTCFG, 32'h0);
      pulse(0);
      rd_chk(dctm_pkg::OFF_T0_LO, 32'hff, 32'h05);
      $display("test events done");
   endtask

   //////////////////////////////////////////////////////////////////////
   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      pulse_req = 2'h0;
      gate_lvl = 2'h0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_m16();
      t_m13();
      t_m8r();
      t_prescale();
      t_events();
      end_sim();
   end
endmodule

`default_nettype wire
